//--- logic/ctpt_timers.v
// Purpose: four 8-bit down timers, cascadable, pwm and toggle out
// Assumes: mclk_i is the crystal clock, APB master on same clock
// Notes:   one wait state on every APB access
//
// Contract
// - outside pwm, a cascaded pair raises one interrupt, the even timer's, at 16-bit zero
// - even timer holds low byte, odd timer holds high byte
// - the timing-out timer reloads its count in the interrupt cycle
// - a cascaded pair always auto-reloads
// - timers keep counting with pending interrupts, pairs independent
// - a second timeout before service is not flagged
// - enabling by control write starts from current count, no load
// - timers tick once every eighth crystal cycle
// - independent timers reload from own low byte, optional reload
// - pwm alternates low pair and high pair 16-bit reloads
// - first pwm reload chosen by pin when toggle active, else low
// - low end gives timer zero irq, high end gives timer one irq
// - timer zero end of count toggles the output flip-flop
// - in pwm the pin falls after high and rises after low
// - after reset all timers are disabled
//
// Design decision made here: the APB slave port.
`include "ctpt_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module ctpt_timers #(
  parameter integer TICK_DIV = `CTPT_TICK_DIV
) (
  input  wire        mclk_i,
  input  wire        rstn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  output wire        irq_o,
  output wire [3:0]  tmr_irq_o,
  output wire        toggle_pin_o,
  output wire        toggle_pin_oe_o
);

  reg  [`CTPT_CTRL_W-1:0] ctrl_q;
  reg  [`CTPT_CTRL_W-1:0] ctrl_d;
  reg  [31:0]             cnt_q;
  reg  [31:0]             cnt_d;
  reg  [31:0]             rlo_q;
  reg  [15:0]             rhi_q;
  reg  [3:0]              sts_q;
  reg  [3:0]              sts_d;
  reg  [3:0]              mask_q;
  reg  [7:0]              pdir_q;
  reg  [7:0]              psfr_q;
  reg  [`CTPT_PRE_W-1:0]  pre_q;
  reg                     tick_q;
  reg                     pwm_first_q;
  reg                     pwm_first_d;
  reg                     pulse_high_reload_pair_q;
  reg                     pulse_high_reload_pair_d;
  reg                     pin_q;
  reg                     pin_d;
  reg  [3:0]              ev;
  reg  [3:0]              en_clr;
  reg  [31:0]             prdata_q;
  reg                     pready_q;
  reg                     pslverr_q;
  reg                     irq_q;
  reg  [3:0]              tirq_q;
  reg                     oe_q;
  reg  [31:0]             rd_d;
  reg                     hit_d;
  reg  [15:0]             c16;
  reg  [15:0]             r16;
  reg                     nxt_hi;
  integer                 p;
  integer                 j;

  wire       acc_done = psel_i & penable_i & pready_q;
  wire       wr_en    = acc_done & pwrite_i;
  wire [3:0] en       = ctrl_q[`CTPT_EN_LSB +: 4];
  wire [3:0] rld      = ctrl_q[`CTPT_RLD_LSB +: 4];
  wire [1:0] cas      = {ctrl_q[`CTPT_CAS23], ctrl_q[`CTPT_CAS01]};
  wire       pwm_on   = ctrl_q[`CTPT_PWM] & ctrl_q[`CTPT_CAS01];
  wire       timer_toggle_output_on  = pdir_q[`CTPT_TIMER_TOGGLE_OUTPUT_BIT] & psfr_q[`CTPT_TIMER_TOGGLE_OUTPUT_BIT];
  wire       wr_ctrl  = wr_en & (paddr_i == `CTPT_A_CTRL);
  wire       wr_sts   = wr_en & (paddr_i == `CTPT_A_STAT);

  // TICK_DIV is informational; the three-bit prescaler fixes the divide at eight
  // divide by eight
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_q  <= {`CTPT_PRE_W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_q + {{(`CTPT_PRE_W-1){1'b0}}, 1'b1};
      tick_q <= (pre_q == `CTPT_PRE_LAST);
    end
  end

  // counting, timeout and reload for each pair
  always @* begin
    cnt_d       = cnt_q;
    ev          = 4'h0;
    en_clr      = 4'h0;
    pwm_first_d = pwm_first_q;
    pulse_high_reload_pair_d    = pulse_high_reload_pair_q;
    pin_d       = pin_q;
    c16         = 16'h0000;
    r16         = 16'h0000;
    nxt_hi      = 1'b0;
    for (p = 0; p < 2; p = p + 1) begin
      if (cas[p]) begin
        c16 = {cnt_q[16*p+8 +: 8], cnt_q[16*p +: 8]};
        // count on regardless of pending status
        if (en[2*p] && tick_q) begin
          if (c16 == 16'h0000) begin
            r16 = {rlo_q[16*p+8 +: 8], rlo_q[16*p +: 8]};
            if (p == 0 && pwm_on) begin
              // first reload by pin or low
              if (pwm_first_q) begin
                nxt_hi = timer_toggle_output_on ? ~pin_q : 1'b0;
              end else begin
                nxt_hi = ~pulse_high_reload_pair_q;
              end
              if (nxt_hi) begin
                r16 = rhi_q;
              end
              // low end timer_zero_interrupt, high end irq1
              ev[0]       = nxt_hi;
              ev[1]       = ~nxt_hi;
              pulse_high_reload_pair_d    = nxt_hi;
              pwm_first_d = 1'b0;
              pin_d       = nxt_hi;
            end else begin
              ev[2*p] = 1'b1;
            end
            cnt_d[16*p +: 16] = r16;
          end else begin
            cnt_d[16*p +: 16] = c16 - 16'h0001;
          end
        end
      end else begin
        for (j = 2*p; j < 2*p+2; j = j + 1) begin
          if (en[j] && tick_q) begin
            if (cnt_q[8*j +: 8] == 8'h00) begin
              ev[j] = 1'b1;
              if (rld[j]) begin
                cnt_d[8*j +: 8] = rlo_q[8*j +: 8];
              end else begin
                // one-shot: stop rather than wrap
                en_clr[j] = 1'b1;
              end
            end else begin
              cnt_d[8*j +: 8] = cnt_q[8*j +: 8] - 8'h01;
            end
          end
        end
      end
    end
    // toggle on timer zero end of count
    if (!pwm_on && ev[0]) begin
      pin_d = ~pin_q;
    end
    // enabling write only arms, no load
    if (wr_ctrl) begin
      pwm_first_d = 1'b1;
    end
  end

  // control register, software write wins over one-shot stop
  always @* begin
    ctrl_d = ctrl_q;
    ctrl_d[`CTPT_EN_LSB +: 4] = en & ~en_clr;
    if (wr_ctrl) begin
      ctrl_d = pwdata_i[`CTPT_CTRL_W-1:0];
    end
  end

  always @* begin
    sts_d = sts_q;
    if (wr_sts) begin
      sts_d = sts_q & ~pwdata_i[3:0];
    end
    sts_d = sts_d | ev;
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q      <= `CTPT_CTRL_RST;
      cnt_q       <= `CTPT_CNT_RST;
      sts_q       <= `CTPT_STS_RST;
      pwm_first_q <= 1'b1;
      pulse_high_reload_pair_q    <= 1'b0;
      pin_q       <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      sts_q       <= sts_d;
      pwm_first_q <= pwm_first_d;
      pulse_high_reload_pair_q    <= pulse_high_reload_pair_d;
      pin_q       <= pin_d;
      cnt_q       <= cnt_d;
      // a software count write wins over the tick of the same cycle
      if (wr_en) begin
        case (paddr_i)
          `CTPT_A_CNT0: begin
            cnt_q[7:0] <= pwdata_i[7:0];
          end
          `CTPT_A_CNT1: begin
            cnt_q[15:8] <= pwdata_i[7:0];
          end
          `CTPT_A_CNT2: begin
            cnt_q[23:16] <= pwdata_i[7:0];
          end
          `CTPT_A_CNT3: begin
            cnt_q[31:24] <= pwdata_i[7:0];
          end
          default: begin
            cnt_q <= cnt_d;
          end
        endcase
      end
    end
  end

  // reload, mask and port b bits change only by software
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rlo_q  <= `CTPT_CNT_RST;
      rhi_q  <= {`CTPT_BYTE_RST, `CTPT_BYTE_RST};
      mask_q <= `CTPT_STS_RST;
      pdir_q <= `CTPT_BYTE_RST;
      psfr_q <= `CTPT_BYTE_RST;
    end else if (wr_en) begin
      case (paddr_i)
        `CTPT_A_MASK: begin
          mask_q <= pwdata_i[3:0];
        end
        `CTPT_A_RLO0: begin
          rlo_q[7:0] <= pwdata_i[7:0];
        end
        `CTPT_A_RLO1: begin
          rlo_q[15:8] <= pwdata_i[7:0];
        end
        `CTPT_A_RLO2: begin
          rlo_q[23:16] <= pwdata_i[7:0];
        end
        `CTPT_A_RLO3: begin
          rlo_q[31:24] <= pwdata_i[7:0];
        end
        `CTPT_A_RHI0: begin
          rhi_q[7:0] <= pwdata_i[7:0];
        end
        `CTPT_A_RHI1: begin
          rhi_q[15:8] <= pwdata_i[7:0];
        end
        `CTPT_A_PDIR: begin
          pdir_q <= pwdata_i[7:0];
        end
        `CTPT_A_PSFR: begin
          psfr_q <= pwdata_i[7:0];
        end
        default: begin
          mask_q <= mask_q;
        end
      endcase
    end
  end

  // read mux and decode
  always @* begin
    rd_d  = 32'h00000000;
    hit_d = 1'b1;
    case (paddr_i)
      `CTPT_A_CTRL: begin
        // live pwm phase and pin level let software pick up a running pwm
        rd_d[`CTPT_CTRL_W-1:0] = ctrl_q;
        rd_d[`CTPT_PWMHI]      = pulse_high_reload_pair_q;
        rd_d[`CTPT_PIN]        = pin_q;
      end
      `CTPT_A_STAT: begin
        rd_d[3:0] = sts_q;
      end
      `CTPT_A_MASK: begin
        rd_d[3:0] = mask_q;
      end
      `CTPT_A_CNT0: begin
        rd_d[7:0] = cnt_q[7:0];
      end
      `CTPT_A_CNT1: begin
        rd_d[7:0] = cnt_q[15:8];
      end
      `CTPT_A_CNT2: begin
        rd_d[7:0] = cnt_q[23:16];
      end
      `CTPT_A_CNT3: begin
        rd_d[7:0] = cnt_q[31:24];
      end
      `CTPT_A_RLO0: begin
        rd_d[7:0] = rlo_q[7:0];
      end
      `CTPT_A_RLO1: begin
        rd_d[7:0] = rlo_q[15:8];
      end
      `CTPT_A_RLO2: begin
        rd_d[7:0] = rlo_q[23:16];
      end
      `CTPT_A_RLO3: begin
        rd_d[7:0] = rlo_q[31:24];
      end
      `CTPT_A_RHI0: begin
        rd_d[7:0] = rhi_q[7:0];
      end
      `CTPT_A_RHI1: begin
        rd_d[7:0] = rhi_q[15:8];
      end
      `CTPT_A_PDIR: begin
        rd_d[7:0] = pdir_q;
      end
      `CTPT_A_PSFR: begin
        rd_d[7:0] = psfr_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // one wait state; read data is registered on the same edge that raises pready
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      irq_q     <= 1'b0;
      tirq_q    <= 4'h0;
      oe_q      <= 1'b0;
    end else begin
      pready_q  <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~hit_d;
      if (psel_i && penable_i && !pready_q && !pwrite_i) begin
        prdata_q <= rd_d;
      end
      // level follows status and mask, so it drops only by a status or mask write
      irq_q  <= |(sts_d & mask_q);
      tirq_q <= ev;
      // pin drives only when port b is set up
      oe_q   <= timer_toggle_output_on;
    end
  end

  assign prdata_o        = prdata_q;
  assign pready_o        = pready_q;
  assign pslverr_o       = pslverr_q;
  assign irq_o           = irq_q;
  assign tmr_irq_o       = tirq_q;
  assign toggle_pin_o    = pin_q;
  assign toggle_pin_oe_o = oe_q;

endmodule

`default_nettype wire

//--- include/ctpt_consts.vh
// Purpose: constants for the cascadable timer block
// Assumes: 40 MHz mclk_i stands for the crystal clock
// Notes:   byte addresses on the APB side
`ifndef CTPT_CONSTS_VH
`define CTPT_CONSTS_VH

`define CTPT_AW            12
`define CTPT_DW            32

// register byte addresses
`define CTPT_A_CTRL        12'h000
`define CTPT_A_STAT        12'h004
`define CTPT_A_MASK        12'h008
`define CTPT_A_CNT0        12'h010
`define CTPT_A_RLO0        12'h020
`define CTPT_A_RHI0        12'h030
`define CTPT_A_RHI1        12'h034
`define CTPT_A_CNT1        12'h014
`define CTPT_A_CNT2        12'h018
`define CTPT_A_CNT3        12'h01C
`define CTPT_A_RLO1        12'h024
`define CTPT_A_RLO2        12'h028
`define CTPT_A_RLO3        12'h02C
`define CTPT_IDX_PDIR      12'h0D6
`define CTPT_IDX_PSFR      12'h0D7
// port b registers sit at four times their index
`define CTPT_A_PDIR        12'h358
`define CTPT_A_PSFR        12'h35C

// control register fields
`define CTPT_EN_LSB        0
`define CTPT_RLD_LSB       4
`define CTPT_CAS01         8
`define CTPT_CAS23         9
`define CTPT_PWM           10
`define CTPT_PWMHI         12
`define CTPT_PIN           13
`define CTPT_CTRL_W        11

// reset values
`define CTPT_CTRL_RST      11'h000
`define CTPT_BYTE_RST      8'h00
`define CTPT_CNT_RST       32'h00000000
`define CTPT_STS_RST       4'h0

// port b bit that carries the toggle output
`define CTPT_TIMER_TOGGLE_OUTPUT_BIT      1

// timing
`define CTPT_TICK_DIV      8
`define CTPT_PRE_W         3
`define CTPT_PRE_LAST      3'h7

`endif

//--- verif/ctpt_port_model.sv
// Purpose: port pin seen outside the timer block
// Assumes: pin has no pull, so it floats when undriven
// Notes:   undriven pin shows inverse of last value so stale data never passes
`timescale 1ns/1ps
`default_nettype none
module ctpt_port_model (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  output var  logic pin_o
);
  logic last_q = 1'b0;
  always @(posedge clk_i) begin
    if (oe_i) last_q <= pin_i;
  end
  assign pin_o = oe_i ? pin_i : ~last_q;
endmodule
`default_nettype wire

//--- verif/ctpt_timers_chk.sv
// Purpose: port assertions for the timer block
// Assumes: one clock, async active-low reset
// Notes:   mode bits are not visible here, so checks are mode-free
`timescale 1ns/1ps
`default_nettype none
module ctpt_timers_chk (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        irq_o,
  input wire logic [3:0]  tmr_irq_o,
  input wire logic        toggle_pin_o,
  input wire logic        toggle_pin_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire wr = pready_o && pwrite_i;
  wire mwr = wr && paddr_i == 12'h008;
  wire swr = wr && (paddr_i == 12'h004 || mwr);
  wire pwr = wr && (paddr_i == 12'h358 || paddr_i == 12'h35C);
  logic [1:0] ev1_q, ev2_q;
  logic       armed_q;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev1_q   <= 2'h0;
      ev2_q   <= 2'h0;
      armed_q <= 1'b0;
    end else begin
      ev1_q   <= tmr_irq_o[1:0];
      ev2_q   <= ev1_q;
      armed_q <= armed_q | (wr && paddr_i == 12'h000);
    end
  end
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i; endsequence
  apb_wait_a: assert property (setup_s ##1 access_s |-> !pready_o ##1 pready_o) else $error("apb answer timing");
  apb_err_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  irq_rise_a: assert property ($rose(irq_o) |-> (|tmr_irq_o) || $past(mwr) || $past(mwr, 2)) else $error("irq rose");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(swr) || $past(swr, 2)) else $error("irq fell");
  tmr0_gap_a: assert property (tmr_irq_o[0] |=> !tmr_irq_o[0] [*7]) else $error("timer zero too fast");
  tmr1_gap_a: assert property (tmr_irq_o[1] |=> !tmr_irq_o[1] [*7]) else $error("timer one too fast");
  idle_reset_a: assert property (|tmr_irq_o |-> armed_q) else $error("timer ran before enable");
  pin_event_a: assert property ($changed(toggle_pin_o) |=> (|tmr_irq_o[1:0]) || (|ev1_q) || (|ev2_q))
    else $error("pin moved without event");
  oe_cfg_a: assert property ($changed(toggle_pin_oe_o) |-> $past(pwr) || $past(pwr, 2)) else $error("oe moved");
endmodule
bind ctpt_timers ctpt_timers_chk i_ctpt_timers_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .tmr_irq_o(tmr_irq_o),
  .toggle_pin_o(toggle_pin_o), .toggle_pin_oe_o(toggle_pin_oe_o));
`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench for the timer block
// Assumes: 40 MHz clock, one apb wait state
// Notes:   tick phase is unknown, so first gaps are ranges
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t %s", $time, m); end end
module tb;
  logic        mclk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, err, pin_lvl;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, rd, prdata_o;
  logic        pready_o, pslverr_o, irq_o, toggle_pin_o, toggle_pin_oe_o;
  logic [3:0]  tmr_irq_o, seen;
  int          error_cnt = 0, comparisons = 0, n;
  // ordinary cases: address, write data, expected byte
  logic [51:0] rows [8] = '{{12'h020, 32'h3, 8'h03}, {12'h024, 32'h1, 8'h01}, {12'h030, 32'h1, 8'h01},
    {12'h034, 32'h100, 8'h00}, {12'h01C, 32'h5A, 8'h5A}, {12'h02C, 32'hFFFFFFC3, 8'hC3},
    {12'h008, 32'hFF, 8'h0F}, {12'h008, 32'hE, 8'h0E}};
  always #12.5 mclk_i = ~mclk_i;
  ctpt_timers i_ctpt_timers (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .tmr_irq_o(tmr_irq_o), .toggle_pin_o(toggle_pin_o), .toggle_pin_oe_o(toggle_pin_oe_o));
  ctpt_port_model i_ctpt_port_model (.clk_i(mclk_i), .pin_i(toggle_pin_o), .oe_i(toggle_pin_oe_o), .pin_o(pin_lvl));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 0;
    pen <= 0;
    @(posedge mclk_i);
  endtask
  task automatic wt(input int b, output int c);
    c = 0;
    do begin
      @(posedge mclk_i);
      c++;
      seen = seen | tmr_irq_o;
    end while (tmr_irq_o[b] !== 1'b1);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    summarize;
  end
  initial begin
    tick(5);
    rstn_i <= 1;
    tick(40);
    apb(0, 12'h004, 0);
    `CHK(rd, 32'h0, "status after reset")
    for (int i = 0; i < 8; i++) begin
      apb(1, rows[i][51:40], rows[i][39:8]);
      apb(0, rows[i][51:40], 0);
      `CHK(rd, {24'h0, rows[i][7:0]}, "readback")
    end
    apb(0, 12'h0FC, 0);
    `CHK({err, rd}, 33'h100000000, "unmapped")
    $display("end of test registers");
    // reload low is 3, so a load would time out far sooner
    apb(1, 12'h010, 8);
    apb(1, 12'h000, 1);
    wt(0, n);
    `CHK(n >= 60 && n <= 80, 1'b1, "start count")
    tick(2);
    `CHK(toggle_pin_o, 1'b1, "pin toggle")
    apb(0, 12'h004, 0);
    `CHK({irq_o, rd[3:0]}, 5'h01, "masked status")
    apb(1, 12'h008, 1);
    tick(1);
    `CHK(irq_o, 1'b1, "irq level")
    apb(1, 12'h004, 1);
    tick(1);
    `CHK(irq_o, 1'b0, "irq cleared")
    apb(0, 12'h000, 0);
    `CHK(rd[0], 1'b0, "one-shot stop")
    $display("end of test oneshot");
    apb(1, 12'h010, 0);
    apb(1, 12'h014, 1);
    seen = 4'h0;
    apb(1, 12'h101, 0);
    `CHK(err, 1'b1, "unmapped write")
    apb(1, 12'h000, 32'h101);
    wt(0, n);
    `CHK(n >= 2040 && n <= 2075, 1'b1, "16-bit span")
    wt(0, n);
    `CHK(n, 2080, "forced reload")
    apb(0, 12'h014, 0);
    `CHK(rd, 32'h1, "high byte")
    `CHK(seen[1], 1'b0, "odd timer irq")
    $display("end of test cascade");
    apb(1, 12'h358, 2);
    apb(1, 12'h35C, 2);
    tick(1);
    `CHK(toggle_pin_oe_o, 1'b1, "pin enable")
    apb(1, 12'h000, 32'h501);
    wt(1, n);
    tick(3);
    `CHK(pin_lvl, 1'b0, "pin after high")
    wt(0, n);
    `CHK(n, 2077, "low period")
    tick(3);
    `CHK(pin_lvl, 1'b1, "pin after low")
    wt(1, n);
    `CHK(n, 13, "high period")
    $display("end of test pwm");
    apb(1, 12'h018, 1);
    apb(1, 12'h028, 2);
    apb(1, 12'h000, 32'h44);
    wt(2, n);
    `CHK(n >= 9 && n <= 16, 1'b1, "timer two start")
    wt(2, n);
    `CHK(n, 24, "timer two reload")
    apb(0, 12'h000, 0);
    `CHK(rd[10:0], 11'h044, "reload keeps enable")
    $display("end of test reload");
    rstn_i <= 0;
    tick(2);
    rstn_i <= 1;
    tick(2);
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0, "control after reset")
    apb(0, 12'h018, 0);
    `CHK(rd, 32'h0, "count after reset")
    $display("end of test reset");
    summarize;
  end
endmodule
`default_nettype wire
